//--- rtl/csag_gate.v
// Command gate: session exclusion, file identifier screening and access rule checking.
// Function
// - With a third-gen session active, legacy class commands get class-not-supported.
// - Refuse third-gen session while legacy session is active, and the reverse.
// - Allow at most one third-gen subscriber session at a time.
// - Identifier 7FFF is reserved for the current application directory.
// - Directory ids 7F10, 7F20-7F25, 7F26-7F2F are operational reserved.
// - 7F4X, 5F1X, 5F2X and their 6FXX or 4FXX files are administrative.
// - Under root, 2F05, 2F06, 2F1X operational; 2FEX administrative.
// - Under root, 2F00 is the application directory file, 2F01 the reset answer.
// - Only select and status run before the file's security condition is met.
// - Security attributes come under referenced, compact or expanded tags.
// - A multi-application card supports the referenced attribute tag.
// - Access mode objects tagged 81 to 8F list further described commands.
// - Command groups with a clear access mode bit are never allowed.
// - Access mode bits decode differently for directories and elementary files.
// - A multi-application card keeps several first-level pins and a universal pin.
// - A single-application card uses one first-level pin, optional second-level pin.
// - Where allowed, the universal pin stands in for the first-level pin.
// - Each access rule pairs one access mode with pin-referencing conditions.
// - Identifier 7FFF resolves to the currently selected application directory.
// - Compact condition byte count equals the ones in access mode bits 6 to 0.
`timescale 1ns/1ps
`include "csag_regs.vh"
module csag_gate #(
    parameter NUM_APPS = 4,
    parameter MULTI_APP = 1
)(
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_cmd_valid,
    input wire [7:0] i_cla,
    input wire [7:0] i_ins,
    input wire [1:0] i_sess_cmd,
    input wire [15:0] i_fid,
    input wire [15:0] i_parent_fid,
    input wire i_is_directory,
    input wire [15:0] i_app_fid,
    input wire [1:0] i_app_index,
    input wire [7:0] i_attr_tag,
    input wire [7:0] i_am_tag,
    input wire [7:0] i_am_byte,
    input wire [7:0] i_sc_count,
    input wire [7:0] i_custom_ins,
    input wire i_custom_listed,
    input wire [7:0] i_sc_byte,
    input wire i_sc_and,
    input wire [7:0] i_sc_byte2,
    input wire i_univ_allowed,
    input wire [NUM_APPS-1:0] i_pin1_verified,
    input wire i_second_level_user_pin_verified,
    input wire i_univ_verified,
    output reg o_rsp_valid,
    output reg [15:0] o_sw,
    output reg o_exec,
    output reg o_sel_commit,
    output reg [15:0] o_resolved_fid,
    output reg o_third_gen_subscriber_app,
    output reg o_legacy_session,
    output reg o_attr_error
);

    function [2:0] ones7;
        input [6:0] v;
        integer k;
        begin
            ones7 = 3'h0;
            for (k = 0; k < 7; k = k + 1)
                ones7 = ones7 + {2'h0, v[k]};
        end
    endfunction

    // Classify one identifier against the reserved ranges, given its parent.
    function [1:0] fid_class;
        input [15:0] fid;
        input [15:0] par;
        begin
            fid_class = `CSAG_FID_NORMAL;
            if (fid == `CSAG_FID_CUR_APP)
                fid_class = `CSAG_FID_OPERATIONAL;
            else if (fid == 16'h7F10 || (fid >= 16'h7F20 && fid <= 16'h7F2F))
                fid_class = `CSAG_FID_OPERATIONAL;
            else if (fid[15:4] == 12'h7F4 || fid[15:4] == 12'h5F1 || fid[15:4] == 12'h5F2)
                fid_class = `CSAG_FID_ADMIN;
            else if (fid[15:8] == 8'h6F && par[15:4] == 12'h7F4)
                fid_class = `CSAG_FID_ADMIN;
            else if (fid[15:8] == 8'h4F && (par[15:4] == 12'h5F1 || par[15:4] == 12'h5F2))
                fid_class = `CSAG_FID_ADMIN;
            else if (par == `CSAG_FID_ROOT)
            begin
                if (fid == 16'h2F05 || fid == 16'h2F06 || fid[15:4] == 12'h2F1)
                    fid_class = `CSAG_FID_OPERATIONAL;
                else if (fid[15:4] == 12'h2FE)
                    fid_class = `CSAG_FID_ADMIN;
                else if (fid == `CSAG_FID_APP_DIR_FILE || fid == `CSAG_FID_ATR_FILE)
                    fid_class = `CSAG_FID_OPERATIONAL;
            end
        end
    endfunction

    // Map instruction to the access mode bit; directories and files differ.
    function [7:0] am_mask;
        input [7:0] ins;
        input is_dir;
        begin
            am_mask = 8'h00;
            if (is_dir)
            begin
                case (ins)
                    8'hE0: am_mask = 8'h01;
                    8'hE4: am_mask = 8'h02;
                    8'h44: am_mask = 8'h08;
                    8'h04: am_mask = 8'h10;
                    8'hE6: am_mask = 8'h20;
                    8'hE8: am_mask = 8'h40;
                    default: am_mask = 8'h00;
                endcase
            end
            else
            begin
                case (ins)
                    8'hB0, 8'hB2, 8'hA2: am_mask = 8'h01;
                    8'hD6, 8'hDC, 8'h32: am_mask = 8'h02;
                    8'h44: am_mask = 8'h08;
                    8'h04: am_mask = 8'h10;
                    8'hE4: am_mask = 8'h40;
                    default: am_mask = 8'h00;
                endcase
            end
        end
    endfunction

    // One condition byte: 00 always, 1X, 8X or 9X a pin key reference, else never.
    function sc_met;
        input [7:0] sc;
        input [NUM_APPS-1:0] pin1;
        input [1:0] app;
        input p2;
        input univ;
        input univ_ok;
        begin
            case (sc[7:4])
                4'h0: sc_met = (sc[3:0] == 4'h0);
                4'h1: sc_met = pin1[app] | (univ_ok & univ);
                4'h8: sc_met = p2;
                4'h9: sc_met = univ;
                default: sc_met = 1'b0;
            endcase
        end
    endfunction

    reg third_gen;
    reg legacy;
    reg [1:0] sess_app;
    reg [15:0] cur_app_fid;
    reg [15:0] next_resolved;
    reg [15:0] next_sw;
    reg next_exec;
    reg next_commit;
    reg next_attr_err;
    reg next_third_gen;
    reg next_legacy;
    reg [1:0] next_sess_app;
    reg [15:0] next_app_fid;
    reg [7:0] mask;
    reg [7:0] am_bits;
    reg granted;
    reg univ_ok;
    reg fmt_ok;
    reg [1:0] cls;

    always @*
    begin
        next_sw = `CSAG_SW_OK;
        next_exec = 1'b0;
        next_commit = 1'b0;
        next_attr_err = 1'b0;
        next_third_gen = third_gen;
        next_legacy = legacy;
        next_sess_app = sess_app;
        next_app_fid = cur_app_fid;
        // The current-application alias is only meaningful with an application open.
        next_resolved = (i_fid == `CSAG_FID_CUR_APP) ? cur_app_fid : i_fid;
        univ_ok = i_univ_allowed && (MULTI_APP != 0);
        // The alias itself is screened, not the directory it stands for, so 7FFF is never created.
        cls = fid_class(i_fid, i_parent_fid);
        mask = am_mask(i_ins, i_is_directory);
        am_bits = i_am_byte;
        fmt_ok = 1'b1;
        granted = 1'b0;
        case (i_attr_tag)
            `CSAG_TAG_COMPACT:
            begin
                // A malformed rule is treated as never allowed rather than trusted.
                if ({5'h00, ones7(i_am_byte[6:0])} != i_sc_count)
                    fmt_ok = 1'b0;
            end
            `CSAG_TAG_EXPANDED, `CSAG_TAG_REFERENCED:
            begin
                if (i_attr_tag == `CSAG_TAG_REFERENCED && MULTI_APP == 0)
                    fmt_ok = 1'b0;
                if (i_am_tag >= `CSAG_TAG_AM_FIRST && i_am_tag <= `CSAG_TAG_AM_LAST)
                begin
                    // A custom object carries its own command list and no access mode byte.
                    mask = (i_custom_listed && i_custom_ins == i_ins) ? 8'h01 : 8'h00;
                    am_bits = 8'h01;
                end
                else if (i_am_tag != `CSAG_TAG_AM_BYTE)
                    fmt_ok = 1'b0;
            end
            default: fmt_ok = 1'b0;
        endcase
        // Clear access mode bits fall back to never allowed.
        if (fmt_ok && (mask & am_bits) != 8'h00)
        begin
            if (i_sc_and)
                granted = sc_met(i_sc_byte, i_pin1_verified, i_app_index, i_second_level_user_pin_verified,
                                 i_univ_verified, univ_ok)
                          & sc_met(i_sc_byte2, i_pin1_verified, i_app_index, i_second_level_user_pin_verified,
                                   i_univ_verified, univ_ok);
            else
                granted = sc_met(i_sc_byte, i_pin1_verified, i_app_index, i_second_level_user_pin_verified,
                                 i_univ_verified, univ_ok)
                          | sc_met(i_sc_byte2, i_pin1_verified, i_app_index, i_second_level_user_pin_verified,
                                   i_univ_verified, univ_ok);
        end
        next_attr_err = ~fmt_ok;
        if (third_gen && i_cla == `CSAG_CLA_LEGACY)
            next_sw = `CSAG_SW_CLA_NOT_SUPPORTED;
        else if (i_ins == `CSAG_INS_SELECT)
        begin
            case (i_sess_cmd)
                `CSAG_SESS_CMD_OPEN_3G:
                begin
                    if (legacy)
                        next_sw = `CSAG_SW_COND_USE;
                    else
                    begin
                        // Opening another one replaces the old session.
                        next_third_gen = 1'b1;
                        next_sess_app = i_app_index;
                        next_app_fid = i_app_fid;
                        next_commit = 1'b1;
                    end
                end
                `CSAG_SESS_CMD_OPEN_LEGACY:
                begin
                    if (third_gen)
                        next_sw = `CSAG_SW_COND_USE;
                    else
                    begin
                        next_legacy = 1'b1;
                        next_commit = 1'b1;
                    end
                end
                `CSAG_SESS_CMD_CLOSE:
                begin
                    next_third_gen = 1'b0;
                    next_legacy = 1'b0;
                    next_commit = 1'b1;
                end
                default:
                begin
                    // Reserved ids may be selected but never created or reassigned.
                    next_commit = 1'b1;
                end
            endcase
        end
        else if (i_ins == `CSAG_INS_STATUS)
            next_exec = 1'b1;
        else if (i_ins == 8'hE0 && cls != `CSAG_FID_NORMAL)
            next_sw = `CSAG_SW_FILE_RESERVED;
        else if (!granted)
            next_sw = `CSAG_SW_SEC_UNMET;
        else
            next_exec = 1'b1;
        if (next_sw != `CSAG_SW_OK)
        begin
            next_commit = 1'b0;
            next_exec = 1'b0;
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            third_gen <= 1'b0;
            legacy <= 1'b0;
            sess_app <= 2'h0;
            cur_app_fid <= `CSAG_FID_CUR_APP;
            o_rsp_valid <= 1'b0;
            o_sw <= `CSAG_SW_OK;
            o_exec <= 1'b0;
            o_sel_commit <= 1'b0;
            o_resolved_fid <= 16'h0000;
            o_third_gen_subscriber_app <= 1'b0;
            o_legacy_session <= 1'b0;
            o_attr_error <= 1'b0;
        end
        else
        begin
            o_rsp_valid <= i_cmd_valid;
            if (i_cmd_valid)
            begin
                third_gen <= next_third_gen;
                legacy <= next_legacy;
                sess_app <= next_sess_app;
                cur_app_fid <= next_app_fid;
                o_sw <= next_sw;
                o_exec <= next_exec;
                o_sel_commit <= next_commit;
                o_resolved_fid <= next_resolved;
                o_third_gen_subscriber_app <= next_third_gen;
                o_legacy_session <= next_legacy;
                o_attr_error <= next_attr_err;
            end
            else
            begin
                o_exec <= 1'b0;
                o_sel_commit <= 1'b0;
            end
        end
    end

endmodule

//--- rtl/csag_regs.vh
// Constants for the card session access gate: codes, identifiers, tags and status words.
`ifndef CSAG_REGS_VH
`define CSAG_REGS_VH
`define CSAG_CLA_LEGACY 8'hA0
`define CSAG_SW_CLA_NOT_SUPPORTED 16'h6E00
`define CSAG_SW_OK 16'h9000
`define CSAG_SW_SEC_UNMET 16'h6982
`define CSAG_SW_COND_USE 16'h6985
`define CSAG_SW_FILE_RESERVED 16'h6A89
`define CSAG_INS_SELECT 8'hA4
`define CSAG_INS_STATUS 8'hF2
`define CSAG_FID_CUR_APP 16'h7FFF
`define CSAG_FID_ROOT 16'h3F00
`define CSAG_FID_APP_DIR_FILE 16'h2F00
`define CSAG_FID_ATR_FILE 16'h2F01
`define CSAG_TAG_REFERENCED 8'h8B
`define CSAG_TAG_COMPACT 8'h8C
`define CSAG_TAG_EXPANDED 8'hAB
`define CSAG_TAG_AM_BYTE 8'h80
`define CSAG_TAG_AM_FIRST 8'h81
`define CSAG_TAG_AM_LAST 8'h8F
`define CSAG_SESS_CMD_NONE 2'h0
`define CSAG_SESS_CMD_OPEN_3G 2'h1
`define CSAG_SESS_CMD_OPEN_LEGACY 2'h2
`define CSAG_SESS_CMD_CLOSE 2'h3
`define CSAG_FID_NORMAL 2'h0
`define CSAG_FID_OPERATIONAL 2'h1
`define CSAG_FID_ADMIN 2'h2
`endif

//--- test/csag_gate_props.sv
// Concurrent checks on the card session access gate ports.
`timescale 1ns/1ps
module csag_gate_props (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_cmd_valid,
    input wire [7:0] i_cla,
    input wire [7:0] i_ins,
    input wire [1:0] i_sess_cmd,
    input wire [15:0] i_fid,
    input wire [7:0] i_attr_tag,
    input wire o_rsp_valid,
    input wire [15:0] o_sw,
    input wire o_exec,
    input wire o_sel_commit,
    input wire o_third_gen_subscriber_app,
    input wire o_legacy_session
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire legacy_in_3g = o_third_gen_subscriber_app && i_cla == 8'hA0;
    wire sel = i_cmd_valid && i_ins == 8'hA4;
    sequence s_refused;
        o_rsp_valid && !o_exec && !o_sel_commit;
    endsequence
    a_rsp_follows: assert property (i_cmd_valid |=> o_rsp_valid) else $error("no response");
    a_idle_quiet: assert property (!i_cmd_valid |=> !o_rsp_valid && !o_exec && !o_sel_commit)
        else $error("pulse without command");
    a_legacy_class: assert property (i_cmd_valid && legacy_in_3g |=> s_refused ##0 o_sw == 16'h6E00)
        else $error("legacy class accepted");
    a_sessions_exclusive: assert property (!(o_third_gen_subscriber_app && o_legacy_session))
        else $error("both sessions active");
    a_open_3g_refused: assert property (sel && o_legacy_session && i_sess_cmd == 2'h1
        |=> s_refused ##0 !o_third_gen_subscriber_app) else $error("third-gen opened");
    a_open_legacy_refused: assert property (sel && o_third_gen_subscriber_app && i_sess_cmd == 2'h2
        |=> s_refused ##0 !o_legacy_session) else $error("legacy opened");
    a_one_third_gen: assert property (sel && !legacy_in_3g && i_sess_cmd == 2'h1
        && o_third_gen_subscriber_app |=> o_third_gen_subscriber_app) else $error("reopen lost");
    a_reserved_cur: assert property (i_cmd_valid && i_ins == 8'hE0 && i_fid == 16'h7FFF
        && !legacy_in_3g |=> s_refused ##0 o_sw == 16'h6A89) else $error("7FFF created");
    a_select_bypass: assert property (sel && i_sess_cmd == 2'h0 && !legacy_in_3g
        |=> o_sel_commit && o_sw == 16'h9000) else $error("select blocked");
    a_refusal_clean: assert property (o_rsp_valid && o_sw != 16'h9000 |-> !o_exec && !o_sel_commit)
        else $error("refused command ran");
    a_unknown_tag: assert property (i_cmd_valid && i_ins != 8'hA4 && i_ins != 8'hF2
        && i_attr_tag != 8'h8B && i_attr_tag != 8'h8C && i_attr_tag != 8'hAB |=> s_refused)
        else $error("unknown tag ran");
endmodule
bind csag_gate csag_gate_props csag_gate_props_inst (.i_sys_clk, .i_rst_n, .i_cmd_valid,
    .i_cla, .i_ins, .i_sess_cmd, .i_fid, .i_attr_tag, .o_rsp_valid, .o_sw, .o_exec,
    .o_sel_commit, .o_third_gen_subscriber_app, .o_legacy_session);

//--- test/csag_term.sv
// Terminal model issuing one command at a time to the card gate.
`timescale 1ns/1ps
module csag_term (
    input wire i_sys_clk,
    output reg o_cmd_valid,
    output reg [7:0] o_cla,
    output reg [7:0] o_ins,
    output reg [1:0] o_sess_cmd,
    output reg [15:0] o_fid
);
    initial
    begin
        o_cmd_valid = 1'b0;
        {o_cla, o_ins, o_sess_cmd, o_fid} = 34'h0;
    end
    // Fields are inverted once valid drops, so a card that samples late sees garbage.
    task send(input [7:0] cla, input [7:0] ins, input [1:0] sess, input [15:0] fid);
    begin
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b1;
        {o_cla, o_ins, o_sess_cmd, o_fid} = {cla, ins, sess, fid};
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b0;
        {o_cla, o_ins, o_sess_cmd, o_fid} = ~{cla, ins, sess, fid};
    end
    endtask
endmodule

//--- test/tb.sv
// Self-checking bench for the card session access gate.
`timescale 1ns/1ps
module tb;
    reg i_sys_clk, i_rst_n, i_is_directory, i_custom_listed, i_sc_and, i_univ_allowed;
    reg i_second_level_user_pin_verified, i_univ_verified;
    reg [1:0] i_app_index;
    reg [3:0] i_pin1_verified;
    reg [7:0] i_attr_tag, i_am_tag, i_am_byte, i_sc_count, i_custom_ins, i_sc_byte, i_sc_byte2;
    reg [15:0] i_parent_fid, i_app_fid;
    wire i_cmd_valid, o_rsp_valid, o_exec, o_sel_commit, o_attr_error;
    wire o_third_gen_subscriber_app, o_legacy_session;
    wire [1:0] i_sess_cmd;
    wire [7:0] i_cla, i_ins;
    wire [15:0] i_fid, o_sw, o_resolved_fid;
    integer n_errors = 0, total_checks = 0, cycles = 0, k;
    reg [16*15-1:0] ids;
    csag_term csag_term_inst (.i_sys_clk, .o_cmd_valid(i_cmd_valid), .o_cla(i_cla),
        .o_ins(i_ins), .o_sess_cmd(i_sess_cmd), .o_fid(i_fid));
    csag_gate csag_gate_inst (.i_sys_clk, .i_rst_n, .i_cmd_valid, .i_cla, .i_ins, .i_sess_cmd,
        .i_fid, .i_parent_fid, .i_is_directory, .i_app_fid, .i_app_index, .i_attr_tag,
        .i_am_tag, .i_am_byte, .i_sc_count, .i_custom_ins, .i_custom_listed, .i_sc_byte,
        .i_sc_and, .i_sc_byte2, .i_univ_allowed, .i_pin1_verified, .i_second_level_user_pin_verified,
        .i_univ_verified, .o_rsp_valid, .o_sw, .o_exec, .o_sel_commit, .o_resolved_fid,
        .o_third_gen_subscriber_app, .o_legacy_session, .o_attr_error);
    initial
    begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task test_done;
    begin
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // 47 commands at two cycles each; the ceiling leaves wide margin.
    always @(posedge i_sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 2000)
        begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task run(input [7:0] cla, input [7:0] ins, input [1:0] sess, input [15:0] fid,
        input [15:0] sw);
    begin
        i_app_fid = fid;
        csag_term_inst.send(cla, ins, sess, fid);
        chk(o_rsp_valid, 16'h0001);
        chk(o_sw, sw);
    end
    endtask
    task ctx(input [7:0] tag, input [7:0] am, input [7:0] cnt, input [7:0] sc);
    begin
        {i_attr_tag, i_am_byte, i_sc_count, i_sc_byte, i_sc_byte2} = {tag, am, cnt, sc, sc};
    end
    endtask
    task do_reset;
    begin
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        chk(o_sw, 16'h9000);
        chk(o_third_gen_subscriber_app, 16'h0000);
        chk(o_legacy_session, 16'h0000);
    end
    endtask
    task t_sessions;
    begin
        run(8'h00, 8'hA4, 2'h2, 16'h7F20, 16'h9000);
        chk(o_legacy_session, 16'h0001);
        run(8'h00, 8'hA4, 2'h1, 16'h7F70, 16'h6985);
        chk(o_third_gen_subscriber_app, 16'h0000);
        run(8'h00, 8'hA4, 2'h3, 16'h7F20, 16'h9000);
        run(8'h00, 8'hA4, 2'h1, 16'h7F70, 16'h9000);
        chk(o_third_gen_subscriber_app, 16'h0001);
        run(8'hA0, 8'hF2, 2'h0, 16'h0000, 16'h6E00);
        run(8'h00, 8'hA4, 2'h2, 16'h7F20, 16'h6985);
        chk(o_legacy_session, 16'h0000);
        run(8'h00, 8'hA4, 2'h1, 16'h7F71, 16'h9000);
        run(8'h00, 8'hA4, 2'h0, 16'h7FFF, 16'h9000);
        chk(o_resolved_fid, 16'h7F71);
    end
    endtask
    task t_reserved;
    begin
        ids = {16'h7FFF, 16'h7F10, 16'h7F20, 16'h7F25, 16'h7F26, 16'h7F2F, 16'h7F40, 16'h7F4F,
            16'h5F1B, 16'h5F2C, 16'h2F05, 16'h2F06, 16'h2F1A, 16'h2FE0, 16'h2FEF};
        for (k = 0; k < 15; k = k + 1)
        begin
            run(8'h00, 8'hE0, 2'h0, ids[16*k +: 16], 16'h6A89);
            chk(o_exec, 16'h0000);
        end
        i_parent_fid = 16'h7F41;
        run(8'h00, 8'hE0, 2'h0, 16'h6F01, 16'h6A89);
        i_parent_fid = 16'h5F12;
        run(8'h00, 8'hE0, 2'h0, 16'h4F07, 16'h6A89);
        i_parent_fid = 16'h3F00;
        run(8'h00, 8'hE0, 2'h0, 16'h7F11, 16'h9000);
        chk(o_exec, 16'h0001);
    end
    endtask
    task t_security;
    begin
        i_is_directory = 1'b0;
        i_parent_fid = 16'h7F70;
        ctx(8'h8C, 8'h01, 8'h01, 8'h10);
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
        run(8'h00, 8'hF2, 2'h0, 16'h6F3A, 16'h9000);
        chk(o_exec, 16'h0001);
        run(8'h00, 8'hA4, 2'h0, 16'h6F3A, 16'h9000);
        chk(o_sel_commit, 16'h0001);
        i_pin1_verified = 4'h2;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
        i_app_index = 2'h1;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h9000);
        chk(o_exec, 16'h0001);
        run(8'h00, 8'hD6, 2'h0, 16'h6F3A, 16'h6982);
        i_pin1_verified = 4'h0;
        i_univ_verified = 1'b1;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
        i_univ_allowed = 1'b1;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h9000);
        ctx(8'h8C, 8'h03, 8'h01, 8'h00);
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
        chk(o_attr_error, 16'h0001);
        ctx(8'h8C, 8'h01, 8'h01, 8'h80);
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
        i_second_level_user_pin_verified = 1'b1;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h9000);
        {i_sc_and, i_sc_byte2, i_second_level_user_pin_verified} = {1'b1, 8'h90, 1'b0};
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
        i_sc_and = 1'b0;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h9000);
    end
    endtask
    task t_tags;
    begin
        ids[47:0] = {8'h8B, 8'h8C, 8'hAB, 8'h8D, 8'h81, 8'h8F};
        ctx(8'h00, 8'h01, 8'h01, 8'h00);
        for (k = 0; k < 4; k = k + 1)
        begin
            i_attr_tag = ids[40-8*k +: 8];
            run(8'h00, 8'hB0, 2'h0, 16'h6F3A, (k < 3) ? 16'h9000 : 16'h6982);
        end
        chk(o_attr_error, 16'h0001);
        ctx(8'hAB, 8'h00, 8'h00, 8'h00);
        i_custom_listed = 1'b1;
        for (k = 0; k < 2; k = k + 1)
        begin
            i_am_tag = ids[8-8*k +: 8];
            run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h9000);
        end
        i_custom_listed = 1'b0;
        run(8'h00, 8'hB0, 2'h0, 16'h6F3A, 16'h6982);
    end
    endtask
    initial
    begin
        {i_rst_n, i_custom_listed, i_sc_and, i_univ_allowed, i_second_level_user_pin_verified} = 5'h0;
        {i_univ_verified, i_app_index, i_pin1_verified, i_app_fid} = 23'h0;
        {i_is_directory, i_am_tag, i_custom_ins, i_parent_fid} = {1'b1, 8'h80, 8'hB0, 16'h3F00};
        ctx(8'h8C, 8'hFF, 8'h07, 8'h00);
        do_reset;
        t_sessions;
        t_reserved;
        t_security;
        t_tags;
        do_reset;
        run(8'h00, 8'hA4, 2'h0, 16'h7FFF, 16'h9000);
        chk(o_resolved_fid, 16'h7FFF);
        test_done;
    end
endmodule
